//--- rtl/bcs_burst_sequencer.sv
// Purpose: Feature register decode and burst column sequencing for a mobile DRAM.
// Assumes: Controller obeys mode rules; inputs synchronous to clock.
// Notes: Bursts may follow back to back; reads of the registers return zero data.
`timescale 1ns/1ps
module bcs_burst_sequencer
  import bcs_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic mode_reg_write,
  input wire logic mode_reg_read,
  input wire logic [7:0] mode_reg_addr,
  input wire logic [7:0] mode_reg_data,
  output logic mode_rd_strobe,
  output logic [7:0] mode_rd_data,
  input wire logic burst_start,
  input wire logic [COL_W-1:1] burst_col,
  input wire logic burst_is_write,
  input wire logic auto_precharge,
  output logic burst_ready,
  output logic beat_valid,
  output logic [COL_W-1:0] beat_col,
  output logic beat_last,
  output logic precharge_start,
  output logic [4:0] burst_len,
  output logic burst_order_type,
  output logic wrap_select,
  output logic [3:0] write_recovery_cycles,
  output logic [3:0] read_latency,
  output logic [2:0] write_latency,
  output logic mode_illegal
);

  // Narrower columns cannot hold a length-16 window, so elaboration stops.
  if (COL_W < 4 || COL_W > 16) begin : g_col_w_check
    $error("COL_W must lie between 4 and 16");
  end

  // ****************************************************************
  // Feature registers
  // ****************************************************************
  logic [7:0] burst_cfg_r;
  logic [BCS_LAT_W-1:0] lat_cfg_r;
  logic wr_burst;
  logic wr_lat;

  assign wr_burst = mode_reg_write && (mode_reg_addr == BCS_ADDR_BURST);
  assign wr_lat = mode_reg_write && (mode_reg_addr == BCS_ADDR_LAT);

  // Writes land whole; reserved bits of the latency register are simply dropped.
  always_ff @(posedge clock) begin
    if (srst) begin
      burst_cfg_r <= BCS_BURST_RESET;
      lat_cfg_r <= BCS_LAT_RESET;
    end else begin
      if (wr_burst) begin
        burst_cfg_r <= mode_reg_data;
      end
      if (wr_lat) begin
        lat_cfg_r <= mode_reg_data[BCS_LAT_W-1:0];
      end
    end
  end

  // Reads are answered with a strobe and zero data, as nothing is readable here.
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_rd_strobe <= 1'b0;
      mode_rd_data <= 8'h00;
    end else begin
      mode_rd_strobe <= mode_reg_read;
      mode_rd_data <= 8'h00;
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  bcs_len_t cfg_len;
  logic [2:0] nwr_code;

  assign cfg_len = bcs_len_of(burst_cfg_r[BCS_LEN_LSB +: 3]);
  assign burst_len = 5'(bcs_last_idx(cfg_len)) + 5'h01;
  assign burst_order_type = burst_cfg_r[BCS_TYPE_BIT];
  assign wrap_select = burst_cfg_r[BCS_WRAP_BIT];
  assign nwr_code = burst_cfg_r[BCS_NWR_LSB +: 3];
  assign write_recovery_cycles = 4'(nwr_code) + BCS_NWR_OFFSET;

  // Latency table; reserved codes read back as the default pair.
  always_comb begin
    read_latency = 4'h3;
    write_latency = 3'h1;
    if (lat_cfg_r != 4'h0 && lat_cfg_r <= BCS_LAT_CODE_MAX) begin
      read_latency = lat_cfg_r + 4'h2;
      unique case (lat_cfg_r)
        4'h1: write_latency = 3'h1;
        4'h2, 4'h3: write_latency = 3'h2;
        4'h4: write_latency = 3'h3;
        default: write_latency = 3'h4;
      endcase
    end
  end

  // Flags combinations the controller must not program; the block still runs them.
  assign mode_illegal = (wrap_select && cfg_len != BCS_LEN4)
    || (burst_order_type && cfg_len == BCS_LEN16);

  // ****************************************************************
  // Burst sequencing
  // ****************************************************************
  bcs_state_t state_r;
  logic [3:0] idx_r;
  logic [3:0] last_idx_r;
  logic [COL_W-1:0] start_r;
  bcs_len_t len_r;
  logic inter_r;
  logic nowrap_r;
  logic wr_ap_r;
  logic take;
  logic run_last;
  logic [COL_W-1:0] col_nxt;

  assign run_last = (state_r == BCS_RUN) && (idx_r == last_idx_r);
  assign burst_ready = (state_r == BCS_IDLE) || run_last;
  assign take = burst_start && burst_ready;

  // A new burst may be taken in the cycle of the previous burst's last index.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= BCS_IDLE;
      idx_r <= 4'h0;
      last_idx_r <= 4'h3;
      start_r <= '0;
      len_r <= BCS_LEN4;
      inter_r <= 1'b0;
      nowrap_r <= 1'b0;
      wr_ap_r <= 1'b0;
    end else if (take) begin
      state_r <= BCS_RUN;
      idx_r <= 4'h0;
      last_idx_r <= bcs_last_idx(cfg_len);
      start_r <= {burst_col, 1'b0};
      len_r <= cfg_len;
      inter_r <= burst_order_type;
      nowrap_r <= wrap_select;
      wr_ap_r <= burst_is_write && auto_precharge;
    end else if (run_last) begin
      state_r <= BCS_IDLE;
    end else if (state_r == BCS_RUN) begin
      idx_r <= idx_r + 4'h1;
    end
  end

  bcs_col_gen #(
    .COL_W(COL_W)
  ) u_col_gen (
    .start_col(start_r),
    .beat_idx(idx_r),
    .len_kind(len_r),
    .interleave(inter_r),
    .no_wrap(nowrap_r),
    .col(col_nxt)
  );

  logic beat_ap_r;

  // Beats appear one cycle behind the index so the column comes from a flop.
  always_ff @(posedge clock) begin
    if (srst) begin
      beat_valid <= 1'b0;
      beat_col <= '0;
      beat_last <= 1'b0;
      beat_ap_r <= 1'b0;
    end else begin
      beat_valid <= (state_r == BCS_RUN);
      beat_col <= col_nxt;
      beat_last <= run_last;
      beat_ap_r <= wr_ap_r;
    end
  end

  // ****************************************************************
  // Write recovery before auto precharge
  // ****************************************************************
  logic [3:0] wr_cnt_r;

  // Counting from the last data beat; a later write burst with auto precharge reloads and wins.
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_cnt_r <= 4'h0;
    end else if (beat_valid && beat_last && beat_ap_r) begin
      wr_cnt_r <= write_recovery_cycles;
    end else if (wr_cnt_r != 4'h0) begin
      wr_cnt_r <= wr_cnt_r - 4'h1;
    end
  end

  assign precharge_start = (wr_cnt_r == 4'h1);

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [3:0] gap_r;
  logic [3:0] gap_nwr_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      gap_r <= 4'h0;
      gap_nwr_r <= 4'h0;
    end else if (beat_valid && beat_last && beat_ap_r) begin
      gap_r <= 4'h1;
      gap_nwr_r <= write_recovery_cycles;
    end else if (gap_r != 4'h0 && gap_r != 4'hF) begin
      gap_r <= gap_r + 4'h1;
    end
  end

  logic [3:0] beat_idx_r;
  logic [2:0] beat_start_r;
  logic beat_int8_r;

  // Index and start of the beat on show; beats lag the index by one cycle, so it is piped.
  always_ff @(posedge clock) begin
    beat_idx_r <= idx_r;
    beat_start_r <= start_r[2:0];
    beat_int8_r <= (state_r == BCS_RUN) && (len_r == BCS_LEN8) && inter_r;
  end

  sequence s_take;
    take;
  endsequence

  sequence s_first_beat;
    ##2 beat_valid;
  endsequence

  a_len_decode: assert property (@(posedge clock) disable iff (srst)
    wr_burst && mode_reg_data[2:0] == 3'h3 |=> burst_len == 5'd8)
    else $error("length code 8 not decoded");
  a_type_bit: assert property (@(posedge clock) disable iff (srst)
    wr_burst |=> burst_order_type == $past(mode_reg_data[3]))
    else $error("burst order type not taken from bit 3");
  a_wrap_bit: assert property (@(posedge clock) disable iff (srst)
    wr_burst |=> wrap_select == $past(mode_reg_data[4]))
    else $error("wrap select not taken from bit 4");
  a_nwr_decode: assert property (@(posedge clock) disable iff (srst)
    wr_burst && mode_reg_data[7:5] == 3'h6 |=> write_recovery_cycles == 4'd8)
    else $error("recovery code 110 not decoded as 8");
  a_prech_delay: assert property (@(posedge clock) disable iff (srst)
    precharge_start |-> gap_r == gap_nwr_r)
    else $error("precharge not at recovery count after last beat");
  a_wrap4_order: assert property (@(posedge clock) disable iff (srst)
    s_take ##0 (cfg_len == BCS_LEN4 && !wrap_select && burst_col[1])
    |-> s_first_beat ##0 beat_col[1:0] == 2'h2 ##1 beat_col[1:0] == 2'h3
    ##1 beat_col[1:0] == 2'h0 ##1 beat_col[1:0] == 2'h1)
    else $error("length 4 wrapped order wrong");
  a_int8_order: assert property (@(posedge clock) disable iff (srst)
    beat_valid && beat_int8_r |-> (beat_col[2:0] ^ beat_start_r) == beat_idx_r[2:0])
    else $error("length 8 interleaved order wrong");
  a_seq16_step: assert property (@(posedge clock) disable iff (srst)
    beat_valid && $past(beat_valid) && !$past(beat_last) && len_r == BCS_LEN16
    |-> beat_col[3:0] == 4'($past(beat_col[3:0]) + 4'h1))
    else $error("length 16 sequential step wrong");
  a_even_start: assert property (@(posedge clock) disable iff (srst)
    s_take |-> s_first_beat ##0 !beat_col[0])
    else $error("burst did not start at an even column");
  a_nowrap_linear: assert property (@(posedge clock) disable iff (srst)
    beat_valid && $past(beat_valid) && !$past(beat_last) && nowrap_r && len_r == BCS_LEN4
    |-> beat_col == $past(beat_col) + COL_W'(1))
    else $error("no-wrap burst not linear");
  a_lat_decode: assert property (@(posedge clock) disable iff (srst)
    wr_lat && mode_reg_data[3:0] == 4'h6 |=> read_latency == 4'd8 && write_latency == 3'd4)
    else $error("latency code 0110 not decoded");
  a_lat_field: assert property (@(posedge clock) disable iff (srst)
    wr_lat && mode_reg_data[3:0] == 4'h3 |=> read_latency == 4'd5 && write_latency == 3'd2)
    else $error("latency field not in bits 3:0");
  a_read_strobe: assert property (@(posedge clock) disable iff (srst)
    mode_reg_read |=> mode_rd_strobe ##1 !mode_rd_strobe || $past(mode_reg_read))
    else $error("read strobe not pulsed");

endmodule : bcs_burst_sequencer

//--- rtl/bcs_col_gen.sv
// Purpose: Column address of one beat within a burst.
// Assumes: Start column has bit 0 at zero; beat index below the burst length.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bcs_col_gen
  import bcs_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic [COL_W-1:0] start_col,
  input wire logic [3:0] beat_idx,
  input wire bcs_len_t len_kind,
  input wire logic interleave,
  input wire logic no_wrap,
  output logic [COL_W-1:0] col
);

  // ****************************************************************
  // Beat ordering
  // ****************************************************************
  // Except for no-wrap length 4, only the low bits inside the wrap window move; upper bits hold the row of columns.
  always_comb begin
    col = start_col;
    unique case (len_kind)
      BCS_LEN4: begin
        if (no_wrap) begin
          col = start_col + COL_W'(beat_idx[1:0]);
        end else begin
          col[1:0] = 2'(start_col[1:0] + beat_idx[1:0]);
        end
      end
      BCS_LEN8: begin
        if (interleave) begin
          col[2:0] = start_col[2:0] ^ beat_idx[2:0];
        end else begin
          col[2:0] = 3'(start_col[2:0] + beat_idx[2:0]);
        end
      end
      BCS_LEN16: begin
        col[3:0] = 4'(start_col[3:0] + beat_idx);
      end
    endcase
  end

endmodule : bcs_col_gen

//--- rtl/bcs_pkg.sv
// Purpose: Constants and types for the burst configuration and sequencer block.
// Assumes: 40 MHz clock, synchronous active-high reset.
// Notes: Field layouts of the two feature registers and their reset values.
// Summary of operation
// - Bit 3 picks sequential (0, default) or interleaved (1) beat order.
// - Bit 4 picks wrap (0) or no-wrap (1); no-wrap is legal at length 4 only.
// - Bits 7:5 give recovery cycles, 001 means 3 up to 110 meaning 8.
// - Precharge after a write burst with auto precharge waits the recovery count.
// - Length 4 wrapped bursts run 0,1,2,3 or 2,3,0,1 by start bit 1.
// - Length 8 wraps modulo 8 when sequential, start XOR beat when interleaved.
// - Length 16 sequential counts modulo 16 from the even start column.
// - Column bit 0 is never carried and is always taken as zero.
// - No-wrap length 4 walks y to y+3 linearly, carrying across the 4-column boundary.
// - Latency register holds latency select in bits 3:0, bits 7:4 reserved.
// - Latency codes 1..6 give read 3,4,5,6,7,8 and write 1,2,2,3,4,4.
// - Feature registers are write-only; reads pulse the strobe with no data.
package bcs_pkg;

  // ****************************************************************
  // Register addresses and reset values
  // ****************************************************************
  localparam logic [7:0] BCS_ADDR_BURST = 8'h01;
  localparam logic [7:0] BCS_ADDR_LAT = 8'h02;
  localparam logic [7:0] BCS_BURST_RESET = 8'h22;
  localparam logic [3:0] BCS_LAT_RESET = 4'h1;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BCS_LEN_LSB = 0;
  localparam int BCS_TYPE_BIT = 3;
  localparam int BCS_WRAP_BIT = 4;
  localparam int BCS_NWR_LSB = 5;
  localparam int BCS_LAT_W = 4;

  // ****************************************************************
  // Codes and counts
  // ****************************************************************
  localparam logic [2:0] BCS_LEN_CODE8 = 3'h3;
  localparam logic [2:0] BCS_LEN_CODE16 = 3'h4;
  localparam logic [3:0] BCS_NWR_OFFSET = 4'h2;
  localparam logic [3:0] BCS_LAT_CODE_MAX = 4'h6;

  typedef enum logic [1:0] {BCS_LEN4, BCS_LEN8, BCS_LEN16} bcs_len_t;
  typedef enum logic {BCS_IDLE, BCS_RUN} bcs_state_t;

  // Length code to length kind; reserved codes fall back to length 4.
  function automatic bcs_len_t bcs_len_of(input logic [2:0] code);
    if (code == BCS_LEN_CODE16) begin
      return BCS_LEN16;
    end else if (code == BCS_LEN_CODE8) begin
      return BCS_LEN8;
    end
    return BCS_LEN4;
  endfunction : bcs_len_of

  // Last beat index of a burst of the given kind.
  function automatic logic [3:0] bcs_last_idx(input bcs_len_t len);
    unique case (len)
      BCS_LEN4: return 4'h3;
      BCS_LEN8: return 4'h7;
      BCS_LEN16: return 4'hF;
    endcase
    return 4'h3;
  endfunction : bcs_last_idx

endpackage : bcs_pkg

//--- tb/bcs_ctl_model.sv
// Purpose: Memory controller model that programs the feature registers and issues bursts.
// Assumes: Every task is called just after a falling clock edge.
// Notes: Released register data and column lines show the inverse of their last value.
`timescale 1ns/1ps
module bcs_ctl_model #(
  parameter int COL_W = 10
) (
  input wire logic clock,
  input wire logic burst_ready,
  output logic mode_reg_write,
  output logic mode_reg_read,
  output logic [7:0] mode_reg_addr,
  output logic [7:0] mode_reg_data,
  output logic burst_start,
  output logic [COL_W-1:1] burst_col,
  output logic burst_is_write,
  output logic auto_precharge
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  // Bursts never accepted within the wait bound; the bench adds these to its mismatches.
  int hangs = 0;

  // Every request line starts low so nothing is taken during reset.
  initial begin
    {mode_reg_write, mode_reg_read, burst_start, burst_is_write, auto_precharge} = '0;
    {mode_reg_addr, mode_reg_data, burst_col} = '0;
  end

  // Register write; latency reserved bits are cleared, one idle cycle follows.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    mode_reg_write = 1'b1;
    mode_reg_addr = a;
    mode_reg_data = (a == 8'h02) ? (d & 8'h0F) : d;
    @(negedge clock);
    mode_reg_write = 1'b0;
    mode_reg_data = ~mode_reg_data;
    @(negedge clock);
  endtask : wr_reg

  // Register read; returns at the falling edge where the strobe should show.
  task automatic rd_reg(input logic [7:0] a);
    mode_reg_read = 1'b1;
    mode_reg_addr = a;
    @(negedge clock);
    mode_reg_read = 1'b0;
  endtask : rd_reg

  // Burst request held until taken; hold keeps it up for a back-to-back follower.
  task automatic burst(input logic [COL_W-1:1] c, input logic w, input logic ap, input logic hold);
    burst_start = 1'b1;
    burst_col = c;
    burst_is_write = w;
    auto_precharge = ap;
    for (int n = 0; n < 40 && burst_ready !== 1'b1; n++) @(negedge clock);
    if (burst_ready !== 1'b1) hangs++;
    @(negedge clock);
    if (!hold) begin
      burst_start = 1'b0;
      burst_col = ~c;
      @(negedge clock);
    end
  endtask : burst
endmodule : bcs_ctl_model

//--- tb/tb.sv
// Purpose: Self-checking bench for register decode and burst column order.
// Assumes: Inputs change at the falling edge; outputs sampled at the falling edge.
// Notes: Bursts use legal starts only; page limits are the controller's side.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t got %0h want %0h", $time, (a), (e)); end end
module tb;
  import bcs_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic mode_reg_write, mode_reg_read, burst_start, burst_is_write, auto_precharge;
  logic [7:0] mode_reg_addr, mode_reg_data, mode_rd_data;
  logic [9:1] burst_col;
  logic mode_rd_strobe, burst_ready, beat_valid, beat_last, precharge_start;
  logic burst_order_type, wrap_select, mode_illegal;
  logic [9:0] beat_col;
  logic [4:0] burst_len;
  logic [3:0] write_recovery_cycles, read_latency;
  logic [2:0] write_latency;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int pc_cyc = -1;
  logic [9:0] cols[$];
  logic lasts[$];
  int bcyc[$];
  logic [7:0] cfg[6] = '{8'h22, 8'h2A, 8'h32, 8'h43, 8'h4B, 8'hC4};
  logic [9:0] st[6] = '{10'h002, 10'h3FA, 10'h106, 10'h006, 10'h006, 10'h00A};
  logic [2:0] wl_tab[6] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};

  // ****************************************************************
  // Clock, cycle count and beat monitor
  // ****************************************************************
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  // Beats are logged at the falling edge, well clear of the launching edge.
  always @(negedge clock) begin
    if (beat_valid === 1'b1) begin
      cols.push_back(beat_col);
      lasts.push_back(beat_last);
      bcyc.push_back(cyc);
    end
    if (precharge_start === 1'b1) pc_cyc = cyc;
  end

  bcs_burst_sequencer bcs_burst_sequencer_inst (.clock, .srst, .mode_reg_write, .mode_reg_read,
    .mode_reg_addr, .mode_reg_data, .mode_rd_strobe, .mode_rd_data, .burst_start, .burst_col,
    .burst_is_write, .auto_precharge, .burst_ready, .beat_valid, .beat_col, .beat_last,
    .precharge_start, .burst_len, .burst_order_type, .wrap_select, .write_recovery_cycles,
    .read_latency, .write_latency, .mode_illegal);
  bcs_ctl_model bcs_ctl_model_inst (.clock, .burst_ready, .mode_reg_write, .mode_reg_read,
    .mode_reg_addr, .mode_reg_data, .burst_start, .burst_col, .burst_is_write, .auto_precharge);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic stop_test;
    fail_count += bcs_ctl_model_inst.hangs;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  function automatic int exp_len(input logic [7:0] d);
    return (d[2:0] == 3'h4) ? 16 : (d[2:0] == 3'h3) ? 8 : 4;
  endfunction : exp_len

  // Expected column: linear for no-wrap, else only the low bits move.
  function automatic logic [9:0] ecol(logic [9:0] s, int i, int len, logic il, logic nw);
    logic [9:0] m;
    m = 10'(len - 1);
    if (nw) return s + 10'(i);
    return (s & ~m) | ((il ? s ^ 10'(i) : s + 10'(i)) & m);
  endfunction : ecol

  task automatic check_cfg(input logic [7:0] d);
    int len;
    len = exp_len(d);
    `CHK(burst_len, 5'(len))
    `CHK(burst_order_type, d[3])
    `CHK(wrap_select, d[4])
    `CHK(write_recovery_cycles, {1'b0, d[7:5]} + 4'h2)
    `CHK(mode_illegal, 1'((d[4] && len != 4) || (len == 16 && d[3])))
  endtask : check_cfg

  // A missing beat within the bound counts as a failure and ends the run.
  task automatic wait_beats(input int n);
    for (int k = 0; k < 60 && cols.size() < n; k++) @(negedge clock);
    if (cols.size() < n) begin
      fail_count++;
      $display("BAD %0t beats missing", $time);
      stop_test();
    end
  endtask : wait_beats

  task automatic check_beats(input logic [9:0] s, input int len, input logic il, input logic nw,
    input int base);
    for (int i = 0; i < len; i++) begin
      `CHK(cols[base+i], ecol(s, i, len, il, nw))
      `CHK(lasts[base+i], 1'(i == len - 1))
    end
  endtask : check_beats

  task automatic clear_log;
    cols.delete();
    lasts.delete();
    bcyc.delete();
    pc_cyc = -1;
  endtask : clear_log

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(negedge clock);
    srst = 1'b0;
    check_cfg(8'h22);
    `CHK(read_latency, 4'h3)
    `CHK(write_latency, 3'h1)
    `CHK(burst_ready, 1'b1)
    bcs_ctl_model_inst.rd_reg(8'h01);
    `CHK(mode_rd_strobe, 1'b1)
    `CHK(mode_rd_data, 8'h00)
    @(negedge clock);
    `CHK(mode_rd_strobe, 1'b0)
    $display("test reset_and_read done");
    // Legal combinations only: no-wrap at length 4, no interleaved length 16.
    for (int i = 0; i < 6; i++) begin
      bcs_ctl_model_inst.wr_reg(8'h01, cfg[i]);
      check_cfg(cfg[i]);
      clear_log();
      bcs_ctl_model_inst.burst(st[i][9:1], 1'b0, 1'b0, 1'b0);
      wait_beats(exp_len(cfg[i]));
      check_beats(st[i], exp_len(cfg[i]), cfg[i][3], cfg[i][4], 0);
    end
    $display("test burst_orders done");
    for (int c = 1; c < 7; c++) begin
      bcs_ctl_model_inst.wr_reg(8'h01, {3'(c), 5'h02});
      `CHK(write_recovery_cycles, 4'(c + 2))
      bcs_ctl_model_inst.wr_reg(8'h02, 8'(c));
      `CHK(read_latency, 4'(c + 2))
      `CHK(write_latency, wl_tab[c-1])
    end
    bcs_ctl_model_inst.wr_reg(8'h03, 8'h05);
    `CHK(read_latency, 4'h8)
    `CHK(write_recovery_cycles, 4'h8)
    bcs_ctl_model_inst.wr_reg(8'h01, 8'h33);
    `CHK(mode_illegal, 1'b1)
    bcs_ctl_model_inst.wr_reg(8'h01, 8'h2C);
    `CHK(mode_illegal, 1'b1)
    $display("test decode_tables done");
    // Back-to-back: write with precharge, then a read that must not retrigger it.
    bcs_ctl_model_inst.wr_reg(8'h01, 8'h22);
    clear_log();
    bcs_ctl_model_inst.burst(9'h000, 1'b1, 1'b1, 1'b1);
    bcs_ctl_model_inst.burst(9'h002, 1'b0, 1'b0, 1'b0);
    wait_beats(8);
    check_beats(10'h000, 4, 1'b0, 1'b0, 0);
    check_beats(10'h004, 4, 1'b0, 1'b0, 4);
    `CHK(bcyc[7] - bcyc[0], 7)
    repeat (12) @(negedge clock);
    `CHK(pc_cyc - bcyc[3], 3)
    bcs_ctl_model_inst.wr_reg(8'h01, 8'hC2);
    clear_log();
    bcs_ctl_model_inst.burst(9'h000, 1'b1, 1'b1, 1'b0);
    wait_beats(4);
    repeat (14) @(negedge clock);
    `CHK(pc_cyc - bcyc[3], 8)
    clear_log();
    bcs_ctl_model_inst.burst(9'h000, 1'b0, 1'b1, 1'b0);
    wait_beats(4);
    repeat (14) @(negedge clock);
    `CHK(pc_cyc, -1)
    $display("test precharge done");
    stop_test();
  end
endmodule : tb
